// ==== design/dmb_pkg.sv ====
// Constants for the drive register bank: addresses, fields, codes.
// Assumes a protocol front end that hands decoded Modbus requests.
// Overview of operation
// R01: Word one bits 2..0: 111 starts, 110 stops, others no command.
// R02: Any stop follows the configured stop method, never a fixed one.
// R03: Word one bit 3 sets reverse, used only with a valid run command.
// R04: Word one bit 9 requests fault reset; 0x0200 alone only resets.
// R05: Word two bits 1..0 stop/start; bits 5..4 forward, reverse, reset.
// R06: Status bit0 running, bit1 reverse, bit2 setpoint reached.
// R07: Status bits 15..8 fault code, zero healthy; bits 7..3 zero.
// R08: Fault code equals display number, overload 0x08, undervoltage 0x1f.
// R09: Frequency registers scaled 1:100, 5000 means 50 Hz.
// R10: Time registers scaled 1:100 s, 300 means three seconds.
// R11: Current registers scaled 1:100 A, 300 means three amperes.
// R12: Two-word write at word one sets command then setpoint; echo header.
// R13: Read at frequency monitor returns byte count two then frequency.
// R14: Read at current monitor returns byte count two then current.
// R15: Single write to a parameter updates it volatile, reply echoes request.
// R16: Address high byte is group, low byte index; control 0x12, status 0x13.
// R17: Failure answers function plus 0x80 with exception code.
// R18: Register after word one holds the main frequency setting.
// R19: Reserved control bits ignored, reserved status bits read zero.
package dmb_pkg;
	localparam logic [15:0] ADDR_ACCEL_TIME_ONE = 16'h010b;
	localparam logic [15:0] ADDR_RUN_FREQ_MON   = 16'h1000;
	localparam logic [15:0] ADDR_OUT_CURR_MON   = 16'h1002;
	localparam logic [15:0] ADDR_CMD_PRIMARY    = 16'h1200;
	localparam logic [15:0] ADDR_MAIN_FREQ      = 16'h1201;
	localparam logic [15:0] ADDR_RUN_STATE      = 16'h1300;
	localparam logic [15:0] ADDR_MODEL_ID       = 16'h1301;
	localparam logic [15:0] ADDR_FAULT_NUMBER   = 16'h1326;
	localparam logic [15:0] ADDR_CMD_ALTERNATE  = 16'h2000;
	localparam logic [15:0] ADDR_MAIN_FREQ_ALT  = 16'h2001;
	localparam logic [7:0]  GRP_CONTROL         = 8'h12;
	localparam logic [7:0]  GRP_STATUS          = 8'h13;
	// Arbitrary neutral model value
	localparam logic [15:0] MODEL_ID_VALUE      = 16'h0001;
	localparam logic [15:0] RST_ACCEL_TIME      = 16'h012c;
	localparam logic [15:0] RST_MAIN_FREQ       = 16'h0000;
	localparam logic [7:0]  FN_READ             = 8'h03;
	localparam logic [7:0]  FN_WRITE_ONE        = 8'h06;
	localparam logic [7:0]  FN_WRITE_MANY       = 8'h10;
	localparam logic [7:0]  FN_ERROR_FLAG       = 8'h80;
	localparam logic [7:0]  EXC_BAD_FUNCTION    = 8'h01;
	localparam logic [7:0]  EXC_BAD_ADDRESS     = 8'h02;
	localparam logic [7:0]  EXC_OUT_OF_LIMITS   = 8'h03;
	localparam logic [7:0]  EXC_READ_ONLY       = 8'h20;
	localparam logic [7:0]  READ_BYTE_COUNT     = 8'h02;
	localparam logic [15:0] MANY_WORD_COUNT     = 16'h0002;
	localparam logic [15:0] ONE_WORD_COUNT      = 16'h0001;
	localparam logic [7:0]  FAULT_NONE          = 8'h00;
	localparam logic [7:0]  FAULT_MOTOR_OVERLOAD = 8'h08;
	localparam logic [7:0]  FAULT_UNDERVOLTAGE  = 8'h1f;
	localparam logic [2:0]  W1_RUN              = 3'b111;
	localparam logic [2:0]  W1_STOP             = 3'b110;
	localparam int          W1_DIR_BIT          = 3;
	localparam int          W1_RESET_BIT        = 9;
	localparam logic [1:0]  W2_STOP             = 2'b01;
	localparam logic [1:0]  W2_START            = 2'b10;
	localparam logic [1:0]  W2_FWD              = 2'b01;
	localparam logic [1:0]  W2_REV              = 2'b10;
	localparam logic [1:0]  W2_RESET            = 2'b11;
	localparam logic [15:0] W1_KEEP_MASK        = 16'h020f;
	localparam logic [15:0] W2_KEEP_MASK        = 16'h0033;
	localparam logic [15:0] FREQ_LIMIT          = 16'hea60;
	typedef enum logic [1:0] {
		DMB_IDLE  = 2'b00,
		DMB_WORD2 = 2'b01,
		DMB_REPLY = 2'b10
	} dmb_state_t;
endpackage

// ==== design/dmb_regs.sv ====
// Register bank of the drive behind a Modbus front end.
// Front end delivers one request with header words, then data words.
`timescale 1ns/100ps
module dmb_regs (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Decoded request
	input  wire logic        req_valid,
	input  wire logic [7:0]  req_func,
	input  wire logic [15:0] req_addr,
	input  wire logic [15:0] req_count,
	input  wire logic        req_data_valid,
	input  wire logic [15:0] req_data,
	// Reply
	output logic             rsp_valid,
	output logic             rsp_error,
	output logic [7:0]       rsp_func,
	output logic [15:0]      rsp_addr,
	output logic [15:0]      rsp_word,
	output logic [7:0]       rsp_exc,
	// Drive side state
	input  wire logic        drv_running,
	input  wire logic        drv_reverse,
	input  wire logic        drv_at_setpoint,
	input  wire logic [7:0]  drv_fault_code,
	input  wire logic [15:0] drv_freq,
	input  wire logic [15:0] drv_current,
	input  wire logic [1:0]  stop_method_select,
	// Drive commands
	output logic             cmd_start,
	output logic             cmd_stop,
	output logic [1:0]       cmd_stop_method,
	output logic             cmd_dir_valid,
	output logic             cmd_reverse,
	output logic             cmd_fault_reset,
	output logic [15:0]      main_freq_set,
	output logic [15:0]      accel_time_one
);
	import dmb_pkg::*;

	typedef struct packed {
		dmb_state_t  state;
		logic [15:0] addr;
		logic [7:0]  func;
		logic [15:0] count;
		logic [15:0] cmd_primary;
		logic [15:0] cmd_alternate;
		logic [15:0] main_freq;
		logic [15:0] accel;
		logic        start;
		logic        stop;
		logic        dir_valid;
		logic        reverse;
		logic        fault_reset;
		logic        rvalid;
		logic        rerror;
		logic [15:0] rword;
		logic [7:0]  rexc;
	} dmb_regs_t;

	dmb_regs_t r;
	dmb_regs_t next_r;

	// Status word with reserved bits forced low
	function automatic logic [15:0] dmb_status(input logic run, input logic rev,
			input logic at_set, input logic [7:0] fault);
		dmb_status = {fault, 5'h00, at_set, rev, run}; // R06 R07 R08 R19
	endfunction

	// Readable address check; the value is picked in the idle decode
	function automatic logic dmb_readable(input logic [15:0] a);
		dmb_readable = (a == ADDR_ACCEL_TIME_ONE) || (a == ADDR_RUN_FREQ_MON)
			|| (a == ADDR_OUT_CURR_MON) || (a == ADDR_CMD_PRIMARY)
			|| (a == ADDR_MAIN_FREQ) || (a == ADDR_RUN_STATE)
			|| (a == ADDR_MODEL_ID) || (a == ADDR_FAULT_NUMBER)
			|| (a == ADDR_CMD_ALTERNATE) || (a == ADDR_MAIN_FREQ_ALT);
	endfunction

	// Writable check; status group is read only
	function automatic logic dmb_writable(input logic [15:0] a);
		dmb_writable = (a == ADDR_ACCEL_TIME_ONE) || (a == ADDR_CMD_PRIMARY)
			|| (a == ADDR_MAIN_FREQ) || (a == ADDR_CMD_ALTERNATE)
			|| (a == ADDR_MAIN_FREQ_ALT);
	endfunction

	// Apply one write word to the copy
	function automatic dmb_regs_t dmb_write(input dmb_regs_t s, input logic [15:0] a,
			input logic [15:0] d);
		dmb_regs_t t;
		t = s;
		if (a == ADDR_CMD_PRIMARY) begin
			t.cmd_primary = d & W1_KEEP_MASK; // R19
			if (d[2:0] == W1_RUN) begin // R01
				t.start = 1'b1;
				t.dir_valid = 1'b1; // R03
				t.reverse = d[W1_DIR_BIT]; // R03
			end else if (d[2:0] == W1_STOP) begin // R01
				t.stop = 1'b1; // R02
			end
			t.fault_reset = d[W1_RESET_BIT]; // R04
		end else if (a == ADDR_CMD_ALTERNATE) begin
			t.cmd_alternate = d & W2_KEEP_MASK; // R19
			if (d[1:0] == W2_STOP)
				t.stop = 1'b1; // R05 R02
			else if (d[1:0] == W2_START)
				t.start = 1'b1; // R05
			if (d[5:4] == W2_FWD || d[5:4] == W2_REV) begin // R05
				t.dir_valid = 1'b1;
				t.reverse = (d[5:4] == W2_REV);
			end else if (d[5:4] == W2_RESET) begin
				t.fault_reset = 1'b1; // R05
			end
		end else if (a == ADDR_MAIN_FREQ || a == ADDR_MAIN_FREQ_ALT) begin
			t.main_freq = d; // R09 R18
		end else if (a == ADDR_ACCEL_TIME_ONE) begin
			t.accel = d; // R10 R15
		end
		return t;
	endfunction

	always_comb begin
		logic [15:0] rd;
		logic        bad;
		logic [7:0]  exc;
		rd = 16'h0000;
		bad = 1'b0;
		exc = EXC_BAD_FUNCTION;
		next_r = r;
		next_r.start = 1'b0;
		next_r.stop = 1'b0;
		next_r.dir_valid = 1'b0;
		next_r.fault_reset = 1'b0;
		next_r.rvalid = 1'b0;
		case (r.state)
		DMB_IDLE: begin
			if (req_valid) begin
				next_r.addr = req_addr; // R16
				next_r.func = req_func;
				next_r.count = req_count;
				if (req_addr == ADDR_ACCEL_TIME_ONE)
					rd = r.accel;
				else if (req_addr == ADDR_RUN_FREQ_MON)
					rd = drv_freq; // R13 R09
				else if (req_addr == ADDR_OUT_CURR_MON)
					rd = drv_current; // R14 R11
				else if (req_addr == ADDR_CMD_PRIMARY)
					rd = r.cmd_primary;
				else if (req_addr == ADDR_MAIN_FREQ || req_addr == ADDR_MAIN_FREQ_ALT)
					rd = r.main_freq;
				else if (req_addr == ADDR_RUN_STATE)
					rd = dmb_status(drv_running, drv_reverse, drv_at_setpoint,
						drv_fault_code);
				else if (req_addr == ADDR_MODEL_ID)
					rd = MODEL_ID_VALUE;
				else if (req_addr == ADDR_FAULT_NUMBER)
					rd = {8'h00, drv_fault_code}; // R08
				else if (req_addr == ADDR_CMD_ALTERNATE)
					rd = r.cmd_alternate;
				case (req_func)
				FN_READ: begin
					if (req_count != ONE_WORD_COUNT) begin
						bad = 1'b1;
						exc = EXC_OUT_OF_LIMITS; // R17
					end else if (!dmb_readable(req_addr)) begin
						bad = 1'b1;
						exc = EXC_BAD_ADDRESS; // R17
					end
				end
				FN_WRITE_ONE: begin
					if (!dmb_readable(req_addr)) begin
						bad = 1'b1;
						exc = EXC_BAD_ADDRESS; // R17
					end else if (!dmb_writable(req_addr)) begin
						bad = 1'b1;
						exc = EXC_READ_ONLY; // R17
					end
				end
				FN_WRITE_MANY: begin
					// Only command plus setpoint pair is supported
					if (req_addr != ADDR_CMD_PRIMARY && req_addr != ADDR_CMD_ALTERNATE) begin
						bad = 1'b1;
						exc = EXC_BAD_ADDRESS; // R17
					end else if (req_count != MANY_WORD_COUNT) begin
						bad = 1'b1;
						exc = EXC_OUT_OF_LIMITS; // R17
					end
				end
				default: begin
					bad = 1'b1;
					exc = EXC_BAD_FUNCTION; // R17
				end
				endcase
				next_r.rerror = bad;
				next_r.rexc = bad ? exc : 8'h00;
				next_r.rword = (req_func == FN_READ) ? rd : 16'h0000;
				if (bad || req_func == FN_READ)
					next_r.state = DMB_REPLY;
				else
					next_r.state = DMB_WORD2;
			end
		end
		DMB_WORD2: begin
			if (req_data_valid) begin
				// Setpoint limit check before anything is applied
				if (r.func == FN_WRITE_MANY && r.count == MANY_WORD_COUNT
						&& r.rexc == 8'h00 && !r.rerror && r.addr[0] == 1'b0) begin
					// First word: command parked in rword until setpoint passes
					next_r.rword = req_data; // R12
					next_r.addr = r.addr + 16'h0001; // R18
					next_r.rexc = 8'h01;
				end else if ((r.addr == ADDR_MAIN_FREQ || r.addr == ADDR_MAIN_FREQ_ALT)
						&& req_data > FREQ_LIMIT) begin
					// Refused setpoint drops a parked command as well
					next_r.rerror = 1'b1;
					next_r.rexc = EXC_OUT_OF_LIMITS; // R17
					if (r.func == FN_WRITE_MANY)
						next_r.addr = r.addr - 16'h0001;
					next_r.state = DMB_REPLY;
				end else begin
					if (r.func == FN_WRITE_ONE)
						next_r.rword = req_data; // R15
					if (r.func == FN_WRITE_MANY) begin
						next_r = dmb_write(next_r, r.addr - 16'h0001, r.rword); // R12
						next_r.addr = r.addr - 16'h0001; // R12
					end
					next_r = dmb_write(next_r, r.addr, req_data); // R12 R15
					next_r.rexc = 8'h00;
					next_r.state = DMB_REPLY;
				end
			end
		end
		DMB_REPLY: begin
			next_r.rvalid = 1'b1;
			next_r.state = DMB_IDLE;
		end
		default: next_r.state = DMB_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			r <= '0;
			r.state <= DMB_IDLE;
			r.accel <= RST_ACCEL_TIME;
			r.main_freq <= RST_MAIN_FREQ;
		end else begin
			r <= next_r;
		end
	end

	// Reply fields; error function code carries the flag bit
	assign rsp_valid = r.rvalid;
	assign rsp_error = r.rerror;
	assign rsp_func = r.rerror ? (r.func | FN_ERROR_FLAG) : r.func; // R17
	assign rsp_addr = r.addr;
	assign rsp_word = (r.func == FN_WRITE_MANY) ? r.count : r.rword; // R12 R13
	assign rsp_exc = r.rerror ? r.rexc : 8'h00;
	assign cmd_start = r.start;
	assign cmd_stop = r.stop;
	assign cmd_stop_method = stop_method_select; // R02
	assign cmd_dir_valid = r.dir_valid;
	assign cmd_reverse = r.reverse;
	assign cmd_fault_reset = r.fault_reset;
	assign main_freq_set = r.main_freq;
	assign accel_time_one = r.accel;
endmodule

// ==== verif/dmb_regs_props.sv ====
// Checker for the drive register bank: command decode, replies, errors.
// Bound to the bank; the header stays steady until the reply comes.
`timescale 1ns/100ps
module dmb_regs_props
	import dmb_pkg::*;
(
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        rst,
	// Request
	input wire logic        req_valid,
	input wire logic [7:0]  req_func,
	input wire logic [15:0] req_addr,
	input wire logic [15:0] req_count,
	input wire logic        req_data_valid,
	input wire logic [15:0] req_data,
	// Reply
	input wire logic        rsp_valid,
	input wire logic        rsp_error,
	input wire logic [7:0]  rsp_func,
	input wire logic [15:0] rsp_word,
	input wire logic [7:0]  rsp_exc,
	// Drive side
	input wire logic [15:0] drv_freq,
	input wire logic [1:0]  stop_method_select,
	input wire logic        cmd_start,
	input wire logic        cmd_stop,
	input wire logic [1:0]  cmd_stop_method,
	input wire logic        cmd_dir_valid,
	input wire logic        cmd_reverse,
	input wire logic        cmd_fault_reset
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	// Single writes only; both words of a 0x10 write carry the same header address, so they cannot be told apart
	wire w1 = req_data_valid && req_func == FN_WRITE_ONE && req_addr == ADDR_CMD_PRIMARY;
	wire w2 = req_data_valid && req_func == FN_WRITE_ONE && req_addr == ADDR_CMD_ALTERNATE;
	wire wa = req_data_valid && req_func == FN_WRITE_ONE && req_addr == ADDR_ACCEL_TIME_ONE;
	wire rf = req_valid && req_func == FN_READ && req_addr == ADDR_RUN_FREQ_MON;
	wire wf = req_data_valid && req_func == FN_WRITE_ONE && req_addr == ADDR_MAIN_FREQ
		&& req_data > FREQ_LIMIT;
	a_stop_method: assert property (cmd_stop |-> cmd_stop_method == stop_method_select)
		else $error("stop ignores method");
	a_run_start: assert property (w1 && req_data[2:0] == W1_RUN |=> cmd_start && !cmd_stop)
		else $error("no start");
	a_stop_cmd: assert property (w1 && req_data[2:0] == W1_STOP |=> cmd_stop && !cmd_start)
		else $error("no stop");
	a_dir_rev: assert property (w1 && req_data[3:0] == 4'hf |=> cmd_dir_valid && cmd_reverse)
		else $error("no reverse");
	a_fault_reset: assert property (w1 && req_data[9] |=> cmd_fault_reset)
		else $error("no fault reset");
	a_alt_start: assert property (w2 && req_data[1:0] == W2_START |=> cmd_start)
		else $error("alt start lost");
	a_alt_rev: assert property (w2 && req_data[5:4] == W2_REV |=> cmd_dir_valid && cmd_reverse)
		else $error("alt reverse lost");
	a_read_freq: assert property (rf && req_count == ONE_WORD_COUNT |-> ##2 rsp_valid && !rsp_error && rsp_word == drv_freq)
		else $error("bad frequency read");
	a_echo_one: assert property (wa |-> ##2 rsp_valid && rsp_word == $past(req_data, 2))
		else $error("no echo");
	a_err_code: assert property (rsp_valid && rsp_error |-> rsp_func[7] && rsp_exc != 8'h00)
		else $error("bad error reply");
	a_limit_err: assert property (wf |-> ##2 rsp_valid && rsp_error && rsp_exc == EXC_OUT_OF_LIMITS)
		else $error("setpoint limit ignored");
endmodule
bind dmb_regs dmb_regs_props i_props (.sys_clk, .rst, .req_valid, .req_func, .req_addr,
	.req_count, .req_data_valid, .req_data, .rsp_valid, .rsp_error, .rsp_func, .rsp_word,
	.rsp_exc, .drv_freq, .stop_method_select, .cmd_start, .cmd_stop, .cmd_stop_method,
	.cmd_dir_valid, .cmd_reverse, .cmd_fault_reset);

// ==== verif/dmb_master_model.sv ====
// Modbus master stand-in: issues decoded requests, captures replies.
// Assumes the pulse handshake and one request outstanding at a time.
`timescale 1ns/100ps
module dmb_master_model
	import dmb_pkg::*;
(
	// Clock
	input  wire logic        sys_clk,
	// Request
	output logic             req_valid,
	output logic [7:0]       req_func,
	output logic [15:0]      req_addr,
	output logic [15:0]      req_count,
	output logic             req_data_valid,
	output logic [15:0]      req_data,
	// Reply
	input  wire logic        rsp_valid,
	input  wire logic        rsp_error,
	input  wire logic [7:0]  rsp_func,
	input  wire logic [15:0] rsp_addr,
	input  wire logic [15:0] rsp_word,
	input  wire logic [7:0]  rsp_exc
);
	logic        got, r_err;
	logic [7:0]  r_func, r_exc;
	logic [15:0] r_addr, r_word;
	initial {req_valid, req_func, req_addr, req_count, req_data_valid, req_data} = '0;
	// Values go out raw in 1:100 units; command word before setpoint
	task automatic xfer(input logic [7:0] f, input logic [15:0] a, c, d0, d1);
		int n;
		n = (f == FN_WRITE_ONE) ? 1 : (f == FN_WRITE_MANY) ? 2 : 0;
		@(posedge sys_clk);
		#1;
		{req_func, req_addr, req_count} = {f, a, c};
		req_valid = 1'b1;
		got = 1'b0;
		for (int k = 0; k < 16 && !got; k++) begin
			@(posedge sys_clk);
			#1;
			if (rsp_valid === 1'b1) begin
				got = 1'b1;
				{r_err, r_func, r_addr, r_word, r_exc} = {rsp_error, rsp_func, rsp_addr, rsp_word, rsp_exc};
			end
			req_valid = 1'b0;
			req_data_valid = (k < n) && !got;
			// Data toggles from the third cycle on, after d0 and d1, so a stale word is never mistaken for a live one
			req_data = (k == 0) ? d0 : (k == 1) ? d1 : ~req_data;
		end
	endtask
endmodule

// ==== verif/dmb_regs_test.sv ====
// Self-checking bench for the drive register bank.
// Requests go through the master model; drive state is held steady except the fault code and stop method select.
`timescale 1ns/100ps
module dmb_regs_test;
	import dmb_pkg::*;
	typedef struct packed {
		logic [7:0]  f;
		logic [15:0] a, c, d;
		logic        e;
		logic [15:0] w;
		logic [7:0]  x;
	} dmb_row_t;
	logic        sys_clk = 1'b0, rst = 1'b1, drv_running = 1'b1, drv_reverse = 1'b1;
	logic        drv_at_setpoint = 1'b1, req_valid, req_data_valid, rsp_valid, rsp_error;
	logic        cmd_start, cmd_stop, cmd_dir_valid, cmd_reverse, cmd_fault_reset;
	logic [1:0]  stop_method_select = 2'b01, cmd_stop_method;
	logic [7:0]  drv_fault_code = FAULT_MOTOR_OVERLOAD, req_func, rsp_func, rsp_exc;
	logic [15:0] drv_freq = 16'h1388, drv_current = 16'h012c, req_addr, req_count, req_data;
	logic [15:0] rsp_addr, rsp_word, main_freq_set, accel_time_one;
	logic [15:0] n_start = 16'h0, n_stop = 16'h0, n_reset = 16'h0, n_dir = 16'h0;
	logic [1:0]  last_method = 2'b00;
	logic        last_rev = 1'b0;
	logic [15:0] w1s [4] = '{16'h0200, 16'h0006, 16'h000f, 16'hfdf8};
	logic [15:0] w2s [6] = '{16'h0002, 16'h0001, 16'h0010, 16'h0020, 16'h0030, 16'h0003};
	int          n_errors = 0, checked = 0, cyc = 0;
	dmb_row_t    rows [12] = '{
		'{FN_READ, ADDR_RUN_FREQ_MON, ONE_WORD_COUNT, 16'h0, 1'b0, 16'h1388, 8'h0},
		'{FN_READ, ADDR_OUT_CURR_MON, ONE_WORD_COUNT, 16'h0, 1'b0, 16'h012c, 8'h0},
		'{FN_WRITE_ONE, ADDR_ACCEL_TIME_ONE, ONE_WORD_COUNT, 16'h0064, 1'b0, 16'h0064, 8'h0},
		'{FN_READ, ADDR_ACCEL_TIME_ONE, ONE_WORD_COUNT, 16'h0, 1'b0, 16'h0064, 8'h0},
		'{FN_READ, ADDR_RUN_STATE, ONE_WORD_COUNT, 16'h0, 1'b0, 16'h0807, 8'h0},
		'{FN_READ, ADDR_FAULT_NUMBER, ONE_WORD_COUNT, 16'h0, 1'b0, 16'h0008, 8'h0},
		'{FN_READ, ADDR_MODEL_ID, ONE_WORD_COUNT, 16'h0, 1'b0, MODEL_ID_VALUE, 8'h0},
		'{8'h04, ADDR_RUN_STATE, ONE_WORD_COUNT, 16'h0, 1'b1, 16'h0, EXC_BAD_FUNCTION},
		'{FN_READ, 16'h1400, ONE_WORD_COUNT, 16'h0, 1'b1, 16'h0, EXC_BAD_ADDRESS},
		'{FN_READ, ADDR_RUN_FREQ_MON, 16'h0002, 16'h0, 1'b1, 16'h0, EXC_OUT_OF_LIMITS},
		'{FN_WRITE_ONE, ADDR_RUN_STATE, ONE_WORD_COUNT, 16'h0001, 1'b1, 16'h0, EXC_READ_ONLY},
		'{FN_WRITE_ONE, ADDR_MAIN_FREQ, ONE_WORD_COUNT, 16'hea61, 1'b1, 16'h0, EXC_OUT_OF_LIMITS}};
	dmb_regs i_dut (.sys_clk, .rst, .req_valid, .req_func, .req_addr, .req_count,
		.req_data_valid, .req_data, .rsp_valid, .rsp_error, .rsp_func, .rsp_addr, .rsp_word,
		.rsp_exc, .drv_running, .drv_reverse, .drv_at_setpoint, .drv_fault_code, .drv_freq,
		.drv_current, .stop_method_select, .cmd_start, .cmd_stop, .cmd_stop_method,
		.cmd_dir_valid, .cmd_reverse, .cmd_fault_reset, .main_freq_set, .accel_time_one);
	dmb_master_model i_master (.sys_clk, .req_valid, .req_func, .req_addr, .req_count,
		.req_data_valid, .req_data, .rsp_valid, .rsp_error, .rsp_func, .rsp_addr,
		.rsp_word, .rsp_exc);
	always #4 sys_clk = ~sys_clk;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		i_master.xfer(FN_WRITE_ONE, a, ONE_WORD_COUNT, d, 16'h0);
		check({15'h0, i_master.got}, 16'h0001);
		check(i_master.r_word, d);
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		i_master.xfer(FN_READ, a, ONE_WORD_COUNT, 16'h0, 16'h0);
		check({15'h0, i_master.got}, 16'h0001);
		check(i_master.r_word, exp);
	endtask
	// Pulse tally; a stuck or missing pulse shows up in the totals
	always @(posedge sys_clk) begin
		cyc++;
		if (cmd_start === 1'b1) n_start++;
		if (cmd_stop === 1'b1) begin
			n_stop++;
			last_method = cmd_stop_method;
		end
		if (cmd_dir_valid === 1'b1) begin
			n_dir++;
			last_rev = cmd_reverse;
		end
		if (cmd_fault_reset === 1'b1) n_reset++;
		if (cyc == 2000) begin
			n_errors++;
			give_verdict();
		end
	end
	initial begin
		repeat (12) @(posedge sys_clk);
		#1 rst = 1'b0;
		check(main_freq_set, RST_MAIN_FREQ);
		check(accel_time_one, RST_ACCEL_TIME);
		foreach (rows[i]) begin
			i_master.xfer(rows[i].f, rows[i].a, rows[i].c, rows[i].d, 16'h0);
			check({14'h0, i_master.got, i_master.r_err}, {14'h0, 1'b1, rows[i].e});
			check({8'h0, i_master.r_func}, {8'h0, rows[i].f | (rows[i].e ? FN_ERROR_FLAG : 8'h0)});
			check({8'h0, i_master.r_exc}, {8'h0, rows[i].x});
			if (!rows[i].e) check(i_master.r_word, rows[i].w);
		end
		check(accel_time_one, 16'h0064);
		check(main_freq_set, RST_MAIN_FREQ);
		i_master.xfer(FN_WRITE_MANY, ADDR_CMD_PRIMARY, MANY_WORD_COUNT, 16'h0007, 16'h1388);
		check(i_master.r_addr, ADDR_CMD_PRIMARY);
		check(i_master.r_word, MANY_WORD_COUNT);
		check(main_freq_set, 16'h1388);
		stop_method_select = 2'b10;
		foreach (w1s[i]) wr(ADDR_CMD_PRIMARY, w1s[i]);
		rd(ADDR_CMD_PRIMARY, 16'h0008);
		foreach (w2s[i]) wr(ADDR_CMD_ALTERNATE, w2s[i]);
		drv_fault_code = FAULT_UNDERVOLTAGE;
		rd(ADDR_RUN_STATE, 16'h1f07);
		check(n_start, 16'h0003);
		check(n_stop, 16'h0002);
		check(n_reset, 16'h0002);
		check(n_dir, 16'h0004);
		check({15'h0, last_rev}, 16'h0001);
		check({14'h0, last_method}, 16'h0002);
		// Mid-run reset must bring back the reset values
		@(posedge sys_clk);
		#1 rst = 1'b1;
		@(posedge sys_clk);
		#1 rst = 1'b0;
		check(main_freq_set, RST_MAIN_FREQ);
		check(accel_time_one, RST_ACCEL_TIME);
		rd(ADDR_CMD_PRIMARY, 16'h0000);
		give_verdict();
	end
endmodule
